// File: hdl/fbp_params.svh
// Sizes, field positions and reset values of the flash protection checker.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef FBP_PARAMS_SVH
`define FBP_PARAMS_SVH

// ****************************************************************
// Array geometry.
// ****************************************************************
`define FBP_FLASH_BYTES 262144
`define FBP_BLOCK_BYTES 1024
`define FBP_UNIT_BLOCKS 2
`define FBP_WORD_BITS 32
`define FBP_BYTE_AW 18
`define FBP_WORD_AW 16
`define FBP_BLOCK_WORD_AW 8
`define FBP_UNIT_COUNT 128
`define FBP_UNIT_AW 7
`define FBP_ERASED_WORD 32'hffffffff

// ****************************************************************
// Field positions.
// ****************************************************************
`define FBP_WADDR_LSB 2
`define FBP_UNIT_LSB 9
`define FBP_BLOCK_LSB 8

// ****************************************************************
// Reset values.
// ****************************************************************
`define FBP_PROT_RESET 2'h0

`endif

// File: hdl/fbp_pkg.sv
// Types shared by the flash protection checker and its array.
// Assumes fbp_params.svh is on the include path.
`include "fbp_params.svh"

package fbp_pkg;

	// ****************************************************************
	// Request kinds, protection modes and sequencer states.
	// ****************************************************************
	typedef enum logic [2:0] {
		CMD_FETCH = 3'h0,
		CMD_DATA_READ = 3'h1,
		CMD_DEBUG_READ = 3'h2,
		CMD_PROGRAM = 3'h3,
		CMD_ERASE = 3'h4
	} fbp_cmd_e;

	typedef enum logic [1:0] {
		PROT_NONE = 2'h0,
		PROT_READ_ONLY = 2'h1,
		PROT_EXEC_ONLY = 2'h2,
		PROT_BOTH = 2'h3
	} fbp_prot_e;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_READ = 4'h2,
		ST_PROG = 4'h4,
		ST_ERASE = 4'h8
	} fbp_state_e;

	// ****************************************************************
	// Module state.
	// ****************************************************************
	typedef struct packed {
		fbp_state_e st;
		logic [`FBP_BLOCK_WORD_AW-1:0] cnt;
		logic [`FBP_WORD_AW-1:0] waddr;
		logic [`FBP_WORD_BITS-1:0] wdata;
		logic busy;
		logic resp_valid;
		logic resp_denied;
		logic [`FBP_WORD_BITS-1:0] rdata;
		logic [2*`FBP_UNIT_COUNT-1:0] prot;
	} fbp_state_s;

	typedef struct packed {
		logic [`FBP_WORD_BITS-1:0] rdata;
	} fbp_arr_s;

endpackage : fbp_pkg

// File: hdl/fbp_flash_array.sv
// Word-wide flash storage array with one synchronous read and one write port.
// Assumes the checker drives every write and keeps write and read in one clock.
`timescale 1ns/1ps
`default_nettype none
`include "fbp_params.svh"

module fbp_flash_array #(
	parameter int WORDS = `FBP_FLASH_BYTES / 4
) (
	input wire logic clk_i,
	input wire logic wr_en_i,
	input wire logic [`FBP_WORD_AW-1:0] wr_addr_i,
	input wire logic [`FBP_WORD_BITS-1:0] wr_data_i,
	input wire logic [`FBP_WORD_AW-1:0] rd_addr_i,
	output logic [`FBP_WORD_BITS-1:0] rd_data_o
);

	logic [`FBP_WORD_BITS-1:0] mem [WORDS];
	fbp_pkg::fbp_arr_s r_reg;
	fbp_pkg::fbp_arr_s r_next;

	// ****************************************************************
	// Storage and read register.
	// ****************************************************************
	always_ff @(posedge clk_i) begin
		if (wr_en_i) begin
			mem[wr_addr_i] <= wr_data_i;
		end
	end

	always_comb begin
		r_next = r_reg;
		r_next.rdata = mem[rd_addr_i];
	end

	always_ff @(posedge clk_i) begin
		r_reg <= r_next;
	end

	assign rd_data_o = r_reg.rdata;

endmodule : fbp_flash_array

`default_nettype wire

// File: hdl/fbp_checker.sv
// Erase, program and read checker for the on-chip flash, with per-unit protection.
// Assumes requesters on the same clock that offer a request only while BUSY_O is low.
`timescale 1ns/1ps
`default_nettype none
`include "fbp_params.svh"

// What this block does
// - Flash holds 256 KB split into 1 KB blocks, each erasable alone.
// - An erase sets every bit of one block to one, nothing else.
// - Two adjacent blocks form one 2 KB unit with its own protection.
// - Each unit is unprotected, read-only or execute-only.
// - Read-only units refuse erase and program and keep their contents.
// - Execute-only units refuse erase, program, data and debugger reads.
module fbp_checker (
	input wire logic CORE_CLK_I,
	input wire logic SRST_I,
	input wire logic REQ_VALID_I,
	input wire logic [2:0] REQ_CMD_I,
	input wire logic [`FBP_BYTE_AW-1:0] REQ_ADDR_I,
	input wire logic [`FBP_WORD_BITS-1:0] REQ_WDATA_I,
	input wire logic PROT_WE_I,
	input wire logic [`FBP_UNIT_AW-1:0] PROT_UNIT_I,
	input wire logic [1:0] PROT_MODE_I,
	output logic BUSY_O,
	output logic RESP_VALID_O,
	output logic RESP_DENIED_O,
	output logic [`FBP_WORD_BITS-1:0] RESP_RDATA_O
);

	fbp_pkg::fbp_state_s r_reg;
	fbp_pkg::fbp_state_s r_next;
	logic [`FBP_WORD_AW-1:0] req_waddr;
	logic [`FBP_WORD_BITS-1:0] mem_rdata;
	logic mem_wr_en;
	logic [`FBP_WORD_AW-1:0] mem_wr_addr;
	logic [`FBP_WORD_BITS-1:0] mem_wr_data;
	logic [1:0] req_mode;

	// ****************************************************************
	// Decoding helpers.
	// ****************************************************************
	function automatic logic [`FBP_UNIT_AW-1:0] unit_of(input logic [`FBP_WORD_AW-1:0] wa);
		unit_of = wa[`FBP_WORD_AW-1:`FBP_UNIT_LSB];
	endfunction : unit_of

	function automatic logic [1:0] mode_of(input logic [2*`FBP_UNIT_COUNT-1:0] tbl,
		input logic [`FBP_UNIT_AW-1:0] u);
		mode_of = tbl[{u, 1'b0} +: 2];
	endfunction : mode_of

	function automatic logic allowed(input logic [2:0] cmd, input logic [1:0] mode);
		logic is_read;
		is_read = (cmd == fbp_pkg::CMD_FETCH) || (cmd == fbp_pkg::CMD_DATA_READ) ||
			(cmd == fbp_pkg::CMD_DEBUG_READ);
		case (mode)
			fbp_pkg::PROT_NONE: allowed = is_read || (cmd == fbp_pkg::CMD_PROGRAM) ||
				(cmd == fbp_pkg::CMD_ERASE);
			fbp_pkg::PROT_READ_ONLY: allowed = is_read;
			default: allowed = (cmd == fbp_pkg::CMD_FETCH);
		endcase
	endfunction : allowed

	assign req_waddr = REQ_ADDR_I[`FBP_BYTE_AW-1:`FBP_WADDR_LSB];
	assign req_mode = mode_of(r_reg.prot, unit_of(req_waddr));

	// ****************************************************************
	// Flash storage.
	// ****************************************************************
	fbp_flash_array #(
		.WORDS(`FBP_FLASH_BYTES / 4)
	) u_array (
		.clk_i(CORE_CLK_I),
		.wr_en_i(mem_wr_en),
		.wr_addr_i(mem_wr_addr),
		.wr_data_i(mem_wr_data),
		.rd_addr_i(req_waddr),
		.rd_data_o(mem_rdata)
	);

	// ****************************************************************
	// Request sequencing.
	// ****************************************************************
	always_comb begin
		r_next = r_reg;
		r_next.resp_valid = 1'b0;
		r_next.resp_denied = 1'b0;
		mem_wr_en = 1'b0;
		mem_wr_addr = r_reg.waddr;
		mem_wr_data = r_reg.wdata;
		if (PROT_WE_I) begin
			r_next.prot[{PROT_UNIT_I, 1'b0} +: 2] = PROT_MODE_I;
		end
		case (r_reg.st)
			fbp_pkg::ST_IDLE: begin
				if (REQ_VALID_I) begin
					r_next.waddr = req_waddr;
					r_next.wdata = REQ_WDATA_I;
					r_next.cnt = '0;
					if (!allowed(REQ_CMD_I, req_mode)) begin
						r_next.resp_valid = 1'b1;
						r_next.resp_denied = 1'b1;
					end else if (REQ_CMD_I == fbp_pkg::CMD_PROGRAM) begin
						r_next.st = fbp_pkg::ST_PROG;
					end else if (REQ_CMD_I == fbp_pkg::CMD_ERASE) begin
						r_next.st = fbp_pkg::ST_ERASE;
					end else begin
						r_next.st = fbp_pkg::ST_READ;
					end
				end
			end
			fbp_pkg::ST_READ: begin
				r_next.rdata = mem_rdata;
				r_next.resp_valid = 1'b1;
				r_next.st = fbp_pkg::ST_IDLE;
			end
			fbp_pkg::ST_PROG: begin
				mem_wr_en = 1'b1;
				mem_wr_data = mem_rdata & r_reg.wdata;
				r_next.resp_valid = 1'b1;
				r_next.st = fbp_pkg::ST_IDLE;
			end
			fbp_pkg::ST_ERASE: begin
				mem_wr_en = 1'b1;
				mem_wr_addr = {r_reg.waddr[`FBP_WORD_AW-1:`FBP_BLOCK_LSB], r_reg.cnt};
				mem_wr_data = `FBP_ERASED_WORD;
				r_next.cnt = r_reg.cnt + 8'h01;
				if (&r_reg.cnt) begin
					r_next.resp_valid = 1'b1;
					r_next.st = fbp_pkg::ST_IDLE;
				end
			end
			default: begin
				r_next.st = fbp_pkg::ST_IDLE;
			end
		endcase
		r_next.busy = (r_next.st != fbp_pkg::ST_IDLE);
	end

	always_ff @(posedge CORE_CLK_I) begin
		if (SRST_I) begin
			r_reg <= '0;
			r_reg.st <= fbp_pkg::ST_IDLE;
		end else begin
			r_reg <= r_next;
		end
	end

	assign BUSY_O = r_reg.busy;
	assign RESP_VALID_O = r_reg.resp_valid;
	assign RESP_DENIED_O = r_reg.resp_denied;
	assign RESP_RDATA_O = r_reg.rdata;

	// ****************************************************************
	// Checks.
	// ****************************************************************
	erase_timing_a: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
		(REQ_VALID_I && !BUSY_O && REQ_CMD_I == fbp_pkg::CMD_ERASE &&
		req_mode == fbp_pkg::PROT_NONE) |-> ##257 (RESP_VALID_O && !RESP_DENIED_O))
		else $error("Erase did not finish after 256 word writes.");

	erase_fill_a: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
		(r_reg.st == fbp_pkg::ST_ERASE) |-> (mem_wr_en && mem_wr_data == `FBP_ERASED_WORD &&
		mem_wr_addr[`FBP_WORD_AW-1:`FBP_BLOCK_LSB] == r_reg.waddr[`FBP_WORD_AW-1:`FBP_BLOCK_LSB]))
		else $error("Erase wrote outside its block or not all ones.");

	unit_table_a: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
		PROT_WE_I |=> (mode_of(r_reg.prot, $past(PROT_UNIT_I)) == $past(PROT_MODE_I)))
		else $error("Protection table did not take the unit setting.");

	ro_read_ok_a: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
		(REQ_VALID_I && !BUSY_O && REQ_CMD_I == fbp_pkg::CMD_DATA_READ &&
		req_mode == fbp_pkg::PROT_READ_ONLY) |=> BUSY_O ##1 (RESP_VALID_O && !RESP_DENIED_O))
		else $error("Read from a read-only unit was not served.");

	ro_write_deny_a: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
		(REQ_VALID_I && !BUSY_O && req_mode != fbp_pkg::PROT_NONE &&
		(REQ_CMD_I == fbp_pkg::CMD_PROGRAM || REQ_CMD_I == fbp_pkg::CMD_ERASE))
		|=> (RESP_VALID_O && RESP_DENIED_O && !BUSY_O && !mem_wr_en))
		else $error("Write to a protected unit was not refused.");

	xo_read_deny_a: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
		(REQ_VALID_I && !BUSY_O && req_mode[1] && REQ_CMD_I != fbp_pkg::CMD_FETCH)
		|=> (RESP_VALID_O && RESP_DENIED_O))
		else $error("Data or debugger read of an execute-only unit was served.");

	xo_fetch_ok_a: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
		(REQ_VALID_I && !BUSY_O && REQ_CMD_I == fbp_pkg::CMD_FETCH)
		|=> !RESP_VALID_O ##1 (RESP_VALID_O && !RESP_DENIED_O))
		else $error("Instruction fetch was refused or late.");

	free_unit_a: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
		(REQ_VALID_I && !BUSY_O && req_mode == fbp_pkg::PROT_NONE && REQ_CMD_I <= 3'h4)
		|=> (BUSY_O && !RESP_VALID_O))
		else $error("Request to an unprotected unit was refused.");

	erase_busy_a: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
		(REQ_VALID_I && !BUSY_O && REQ_CMD_I == fbp_pkg::CMD_ERASE &&
		req_mode == fbp_pkg::PROT_NONE) |-> ##1 BUSY_O ##255 BUSY_O ##1 !BUSY_O)
		else $error("Erase did not stay busy for exactly 256 cycles.");

	unit_pair_a: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
		req_mode ==
		r_reg.prot[{REQ_ADDR_I[`FBP_BYTE_AW-1:`FBP_BYTE_AW-`FBP_UNIT_AW], 1'b0} +: 2])
		else $error("Both blocks of a unit did not share one setting.");

	deny_idle_a: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
		RESP_DENIED_O |-> (RESP_VALID_O && !BUSY_O && !mem_wr_en))
		else $error("A refusal came with a busy checker or an array write.");

	ro_debug_ok_a: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
		(REQ_VALID_I && !BUSY_O && REQ_CMD_I == fbp_pkg::CMD_DEBUG_READ &&
		req_mode == fbp_pkg::PROT_READ_ONLY) |=> BUSY_O ##1 (RESP_VALID_O && !RESP_DENIED_O))
		else $error("Debugger read of a read-only unit was not served.");

	rdata_hold_a: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
		(!$stable(RESP_RDATA_O) && !$past(SRST_I)) |-> (RESP_VALID_O && !RESP_DENIED_O))
		else $error("Read data changed without a served read.");

	prog_write_a: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
		(REQ_VALID_I && !BUSY_O && REQ_CMD_I == fbp_pkg::CMD_PROGRAM &&
		req_mode == fbp_pkg::PROT_NONE) |=> (mem_wr_en && mem_wr_addr == $past(req_waddr)))
		else $error("Program of an unprotected unit did not write its word.");

endmodule : fbp_checker

`default_nettype wire

// File: dv/fbp_requester.sv
// Requester model standing for the fetch, data and debugger buses.
// Assumes the bench calls send only while no other send is running.
`timescale 1ns/1ps
`default_nettype none
`include "fbp_params.svh"

module fbp_requester (
	input wire logic clk_i,
	input wire logic busy_i,
	output logic valid_o,
	output logic [2:0] cmd_o,
	output logic [`FBP_BYTE_AW-1:0] addr_o,
	output logic [`FBP_WORD_BITS-1:0] wdata_o
);
	initial begin
		valid_o = 1'b0;
		cmd_o = 3'h7;
		addr_o = '1;
		wdata_o = '1;
	end

	// ****************************************************************
	// Holds a request until it is taken, then inverts the idle lines.
	// ****************************************************************
	task automatic send(input logic [2:0] c, input logic [17:0] a, input logic [31:0] d);
		@(negedge clk_i);
		valid_o = 1'b1;
		cmd_o = c;
		addr_o = a;
		wdata_o = d;
		while (busy_i !== 1'b0) @(negedge clk_i);
		@(posedge clk_i);
		@(negedge clk_i);
		valid_o = 1'b0;
		cmd_o = ~c;
		addr_o = ~a;
		wdata_o = ~d;
	endtask : send
endmodule : fbp_requester
`default_nettype wire

// File: dv/flash_block_protection_tb.sv
// Self-checking bench of the flash protection checker.
// Assumes the design files and fbp_params.svh are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "fbp_params.svh"

module flash_block_protection_tb;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic pwe = 1'b0;
	logic [6:0] punit = 7'h00;
	logic [1:0] pmode = 2'h0;
	wire logic vld;
	wire logic [2:0] cmd;
	wire logic [17:0] addr;
	wire logic [31:0] wd;
	logic busy, rv, rden;
	logic [31:0] rdat;
	logic [31:0] last = 32'h0;
	logic [31:0] mem [int];
	int prot [128];
	int err_count = 0;
	int compares = 0;
	int cyc = 0;
	integer seed = 32'h09085635;
	logic [31:0] r;

	always #4 clk = ~clk;

	fbp_requester u_fbp_requester (.clk_i(clk), .busy_i(busy), .valid_o(vld), .cmd_o(cmd),
		.addr_o(addr), .wdata_o(wd));
	fbp_checker u_fbp_checker (.CORE_CLK_I(clk), .SRST_I(srst), .REQ_VALID_I(vld),
		.REQ_CMD_I(cmd), .REQ_ADDR_I(addr), .REQ_WDATA_I(wd), .PROT_WE_I(pwe),
		.PROT_UNIT_I(punit), .PROT_MODE_I(pmode), .BUSY_O(busy), .RESP_VALID_O(rv),
		.RESP_DENIED_O(rden), .RESP_RDATA_O(rdat));

	// ****************************************************************
	// Comparison, verdict and cycle ceiling.
	// ****************************************************************
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : check

	task automatic stop_test;
		$display("err_count %0d compares %0d", err_count, compares);
		if (err_count == 0 && compares > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : stop_test

	always @(posedge clk) begin
		cyc++;
		if (cyc > 30000) begin
			err_count++;
			stop_test();
		end
	end

	// ****************************************************************
	// Protection writes and requests against the reference model.
	// ****************************************************************
	task automatic setp(input int u, input int m);
		@(negedge clk);
		pwe = 1'b1;
		punit = u[6:0];
		pmode = m[1:0];
		prot[u] = m;
		@(negedge clk);
		pwe = 1'b0;
	endtask : setp

	task automatic req(input logic [2:0] c, input logic [17:0] a, input logic [31:0] d);
		int m;
		int w;
		logic den;
		m = prot[a[17:11]];
		w = a[17:2];
		den = (c > 4) || (c >= 3 && m != 0) || ((c == 1 || c == 2) && m >= 2);
		u_fbp_requester.send(c, a, d);
		for (int i = 0; i < 300 && rv !== 1'b1; i++) @(negedge clk);
		check(rv, 32'h1);
		check(rden, den);
		if (!den && c <= 2) last = mem[w];
		if (!den && c == 3) mem[w] = mem[w] & d;
		if (!den && c == 4) for (int k = 0; k < 256; k++) mem[{a[17:10], k[7:0]}] = '1;
		check(rdat, last);
	endtask : req

	// ****************************************************************
	// Main sequence.
	// ****************************************************************
	initial begin
		repeat (6) @(posedge clk);
		@(negedge clk) srst = 1'b0;
		check({busy, rv, rden}, 32'h0);
		check(rdat, 32'h0);
		for (int b = 4; b < 8; b++) req(3'h4, {b[7:0], 10'h0}, 32'h0);
		req(3'h3, {8'h05, 8'h03, 2'h0}, $random(seed));
		req(3'h3, {8'h04, 8'h03, 2'h0}, $random(seed));
		req(3'h4, {8'h04, 10'h0}, 32'h0);
		req(3'h0, {8'h05, 8'h03, 2'h0}, 32'h0);
		req(3'h1, {8'h04, 8'h03, 2'h0}, 32'h0);
		for (int m = 0; m < 4; m++) begin
			setp(2, m);
			for (int c = 0; c < 8; c++) begin
				req(c[2:0], {7'h02, c[0], 8'h03, 2'h0}, $random(seed));
			end
			req(3'h2, {7'h03, 1'b0, 8'h03, 2'h0}, 32'h0);
		end
		for (int n = 0; n < 40; n++) begin
			r = $random(seed);
			setp(2 + r[0], r[3:2]);
			req(r[10:8] % 5, {7'h02 + r[0], r[1], r[19:12], 2'h0}, $random(seed));
		end
		setp(2, 1);
		@(negedge clk) srst = 1'b1;
		@(negedge clk) srst = 1'b0;
		foreach (prot[i]) prot[i] = 0;
		last = 32'h0;
		check({busy, rv, rden}, 32'h0);
		check(rdat, last);
		req(3'h3, {8'h04, 8'h03, 2'h0}, $random(seed));
		req(3'h1, {8'h04, 8'h03, 2'h0}, 32'h0);
		stop_test();
	end
endmodule : flash_block_protection_tb
`default_nettype wire
